/* File: src/pif_irq_group.v */
// Peripheral interrupt group: enable and flag registers with gated request output.
// Assumes an APB master on pclk; source event inputs are one-cycle pulses on pclk.
`timescale 1ns/1ps
`include "pif_regs.vh"

module pif_irq_group (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [7:0] src_event,
  input wire serial_rx_flag,
  input wire serial_tx_flag,
  output wire peripheral_irq,
  output wire cpu_irq
);

  // ****************************************
  // Registers
  // ****************************************
  reg [7:0] peripheral_irq_enable;
  reg [7:0] flag_store;
  reg [7:0] global_irq_control;
  wire [7:0] peripheral_irq_flags;
  wire wr_access;
  wire hit_enable;
  wire hit_flags;
  wire hit_ctrl;
  wire [7:0] wbyte;
  wire [7:0] next_flags;

  // Bus decode; zero wait states
  assign pready = 1'b1;
  assign wr_access = psel & penable & pwrite;
  assign hit_enable = (paddr == `PIF_ENABLE_OFFSET);
  assign hit_flags = (paddr == `PIF_FLAGS_OFFSET);
  assign hit_ctrl = (paddr == `PIF_GROUP_CTRL_OFFSET);
  assign pslverr = psel & penable & ~(hit_enable | hit_flags | hit_ctrl);
  assign wbyte = pwdata[7:0];

  // ****************************************
  // Access strobes
  // ****************************************
  // Write strobes fire in the access phase, the cycle the transfer completes
  wire wr_enable_reg;
  wire wr_flags_reg;
  wire wr_ctrl_reg;
  // Read setup strobe loads the read data one cycle ahead of the access phase
  wire rd_setup;

  assign wr_enable_reg = wr_access & hit_enable;
  assign wr_flags_reg = wr_access & hit_flags;
  assign wr_ctrl_reg = wr_access & hit_ctrl;
  assign rd_setup = psel & ~penable & ~pwrite;

  // ****************************************
  // Enable register
  // ****************************************
  // Cleared on reset; every bit is plain read/write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peripheral_irq_enable <= `PIF_ENABLE_RESET;
    end else if (wr_enable_reg) begin
      peripheral_irq_enable <= wbyte;
    end
  end

  // ****************************************
  // Global control register
  // ****************************************
  // Only the global and group enable bits exist; the rest read zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_irq_control <= `PIF_CTRL_RESET;
    end else if (wr_ctrl_reg) begin
      global_irq_control <= wbyte & `PIF_CTRL_WMASK;
    end
  end

  // ****************************************
  // Source events
  // ****************************************
  // One pulse per source; the serial positions carry no event of their own
  wire parport_access_event;
  wire converter_done_event;
  wire sync_serial_event;
  wire capcomp1_event;
  wire timer2_match_event;
  wire timer1_overflow_event;
  wire [7:0] event_vec;

  assign parport_access_event = src_event[`PIF_BIT_PARPORT];
  assign converter_done_event = src_event[`PIF_BIT_CONVERTER];
  assign sync_serial_event = src_event[`PIF_BIT_SYNC_SERIAL];
  assign capcomp1_event = src_event[`PIF_BIT_CAPCOMP1];
  assign timer2_match_event = src_event[`PIF_BIT_TIMER2];
  assign timer1_overflow_event = src_event[`PIF_BIT_TIMER1];
  // Serial positions forced low so a stray pulse cannot latch there
  assign event_vec = {parport_access_event, converter_done_event, 2'b00,
                      sync_serial_event, capcomp1_event, timer2_match_event,
                      timer1_overflow_event};

  // ****************************************
  // Flag register
  // ****************************************
  // Software value on a write, else hold; an event in the same cycle wins
  assign next_flags = (wr_flags_reg ? wbyte : flag_store) | event_vec;

  // Flags latch regardless of any enable; only writable positions are stored
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_store <= `PIF_FLAGS_RESET;
    end else begin
      flag_store <= next_flags & `PIF_FLAGS_WMASK;
    end
  end

  // Serial flags follow their unit's buffer state and are read-only
  assign peripheral_irq_flags = {flag_store[7:6], serial_rx_flag, serial_tx_flag,
                                 flag_store[3:0]};

  // ****************************************
  // Named enable bits
  // ****************************************
  // One wire per source keeps the request equation readable
  wire parport_access_enable;
  wire converter_done_enable;
  wire serial_rx_enable;
  wire serial_tx_enable;
  wire sync_serial_enable;
  wire capcomp1_enable;
  wire timer2_match_enable;
  wire timer1_overflow_enable;

  assign parport_access_enable = peripheral_irq_enable[`PIF_BIT_PARPORT];
  assign converter_done_enable = peripheral_irq_enable[`PIF_BIT_CONVERTER];
  assign serial_rx_enable = peripheral_irq_enable[`PIF_BIT_SERIAL_RX];
  assign serial_tx_enable = peripheral_irq_enable[`PIF_BIT_SERIAL_TX];
  assign sync_serial_enable = peripheral_irq_enable[`PIF_BIT_SYNC_SERIAL];
  assign capcomp1_enable = peripheral_irq_enable[`PIF_BIT_CAPCOMP1];
  assign timer2_match_enable = peripheral_irq_enable[`PIF_BIT_TIMER2];
  assign timer1_overflow_enable = peripheral_irq_enable[`PIF_BIT_TIMER1];

  // ****************************************
  // Named flag bits
  // ****************************************
  // Serial flags are the input ports themselves, so they need no view here
  wire parport_access_flag;
  wire converter_done_flag;
  wire sync_serial_flag;
  wire capcomp1_flag;
  wire timer2_match_flag;
  wire timer1_overflow_flag;

  assign parport_access_flag = peripheral_irq_flags[`PIF_BIT_PARPORT];
  assign converter_done_flag = peripheral_irq_flags[`PIF_BIT_CONVERTER];
  assign sync_serial_flag = peripheral_irq_flags[`PIF_BIT_SYNC_SERIAL];
  assign capcomp1_flag = peripheral_irq_flags[`PIF_BIT_CAPCOMP1];
  assign timer2_match_flag = peripheral_irq_flags[`PIF_BIT_TIMER2];
  assign timer1_overflow_flag = peripheral_irq_flags[`PIF_BIT_TIMER1];

  // ****************************************
  // Source slots
  // ****************************************
  // Each slot asks for service while its flag and enable are both set
  wire parport_access_pending;
  wire converter_done_pending;
  wire serial_rx_pending;
  wire serial_tx_pending;
  wire sync_serial_pending;
  wire capcomp1_pending;
  wire timer2_match_pending;
  wire timer1_overflow_pending;

  // Parallel port access
  pif_src_slot u_slot_parport (
    .flag(parport_access_flag),
    .enable(parport_access_enable),
    .pending(parport_access_pending)
  );

  // Converter done
  pif_src_slot u_slot_converter (
    .flag(converter_done_flag),
    .enable(converter_done_enable),
    .pending(converter_done_pending)
  );

  // Serial receive buffer full
  pif_src_slot u_slot_serial_rx (
    .flag(serial_rx_flag),
    .enable(serial_rx_enable),
    .pending(serial_rx_pending)
  );

  // Serial transmit buffer empty
  pif_src_slot u_slot_serial_tx (
    .flag(serial_tx_flag),
    .enable(serial_tx_enable),
    .pending(serial_tx_pending)
  );

  // Synchronous serial port
  pif_src_slot u_slot_sync_serial (
    .flag(sync_serial_flag),
    .enable(sync_serial_enable),
    .pending(sync_serial_pending)
  );

  // Capture/compare one
  pif_src_slot u_slot_capcomp1 (
    .flag(capcomp1_flag),
    .enable(capcomp1_enable),
    .pending(capcomp1_pending)
  );

  // Timer2 period match
  pif_src_slot u_slot_timer2 (
    .flag(timer2_match_flag),
    .enable(timer2_match_enable),
    .pending(timer2_match_pending)
  );

  // Timer1 overflow
  pif_src_slot u_slot_timer1 (
    .flag(timer1_overflow_flag),
    .enable(timer1_overflow_enable),
    .pending(timer1_overflow_pending)
  );

  // ****************************************
  // Request outputs
  // ****************************************
  // Group and global enable bits of the control register
  wire peripheral_group_enable;
  wire global_irq_enable;
  wire group_pending;

  assign peripheral_group_enable = global_irq_control[`PIF_BIT_GROUP_EN];
  assign global_irq_enable = global_irq_control[`PIF_BIT_GLOBAL_EN];

  // Any source whose flag and enable are both set
  assign group_pending = parport_access_pending | converter_done_pending |
                         serial_rx_pending | serial_tx_pending |
                         sync_serial_pending | capcomp1_pending |
                         timer2_match_pending | timer1_overflow_pending;

  // Group enable blocks every source at once; the core also needs the global enable
  assign peripheral_irq = peripheral_group_enable & group_pending;
  assign cpu_irq = peripheral_irq & global_irq_enable;

  // ****************************************
  // Read data
  // ****************************************
  // Register selected by address; unmapped reads return zero
  reg [7:0] next_rdbyte;

  always @* begin
    next_rdbyte = 8'h00;
    if (hit_enable) begin
      next_rdbyte = peripheral_irq_enable;
    end else if (hit_flags) begin
      next_rdbyte = peripheral_irq_flags;
    end else if (hit_ctrl) begin
      next_rdbyte = global_irq_control;
    end
  end

  // Loaded in the setup cycle so the data stand for the whole access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      prdata <= {24'h000000, next_rdbyte};
    end
  end

endmodule

// ****************************************
// One interrupt source slot
// ****************************************
// A source asks for service while its flag and its enable are both set
module pif_src_slot (
  input wire flag,
  input wire enable,
  output wire pending
);

  assign pending = flag & enable;

endmodule

/* File: src/pif_regs.vh */
// Register map, field positions and reset values of the peripheral interrupt group.
// Assumes an APB master with 32-bit data; each register is one aligned word.
`ifndef PIF_REGS_VH
`define PIF_REGS_VH

// ****************************************
// Offsets
// ****************************************
`define PIF_ENABLE_OFFSET 12'h08c
`define PIF_FLAGS_OFFSET 12'h00c
`define PIF_GROUP_CTRL_OFFSET 12'h010

// ****************************************
// Field positions
// ****************************************
`define PIF_BIT_PARPORT 3'h7
`define PIF_BIT_CONVERTER 3'h6
`define PIF_BIT_SERIAL_RX 3'h5
`define PIF_BIT_SERIAL_TX 3'h4
`define PIF_BIT_SYNC_SERIAL 3'h3
`define PIF_BIT_CAPCOMP1 3'h2
`define PIF_BIT_TIMER2 3'h1
`define PIF_BIT_TIMER1 3'h0
`define PIF_BIT_GLOBAL_EN 3'h7
`define PIF_BIT_GROUP_EN 3'h6

// ****************************************
// Reset values and write masks
// ****************************************
`define PIF_ENABLE_RESET 8'h00
`define PIF_FLAGS_RESET 8'h00
`define PIF_CTRL_RESET 8'h00
`define PIF_FLAGS_WMASK 8'hcf
`define PIF_CTRL_WMASK 8'hc0

`endif

/* File: test/pif_src_model.sv */
// Peripheral event source model: pulses events, holds serial flag levels.
// Assumes it is driven from the bench on the pclk rising edge.
`timescale 1ns/1ps
module pif_src_model(input logic pclk, output logic [7:0] src_event = 8'h00,
  output logic rx = 1'b0, output logic tx = 1'b0);
  // One-cycle event pulse per set bit
  task pulse(input logic [7:0] e);
    @(posedge pclk) src_event <= e;
    @(posedge pclk) src_event <= 8'h00;
  endtask
  // Serial unit status levels
  task ser(input logic [1:0] v);
    @(posedge pclk) {rx, tx} <= v;
  endtask
endmodule

/* File: test/pif_irq_group_assertions.sv */
// Port checker for the peripheral interrupt group; bound below.
`timescale 1ns/1ps
module pif_chk(input logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
  serial_rx_flag, serial_tx_flag, peripheral_irq, cpu_irq,
  input logic [11:0] paddr, input logic [31:0] prdata);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd = psel && penable && !pwrite;
  a_cpu_gated: assert property (cpu_irq |-> peripheral_irq) else $error("cpu irq ungated");
  a_rst_quiet: assert property ($rose(presetn) |-> !peripheral_irq) else $error("irq at reset");
  a_ro_serial: assert property (rd && paddr == 12'h00c |->
    prdata[5:4] == $past({serial_rx_flag, serial_tx_flag})) else $error("serial bits wrong");
  a_upper_zero: assert property (rd |-> prdata[31:8] == 24'h0) else $error("upper bits set");
  a_irq_held: assert property (peripheral_irq && !psel && !serial_rx_flag && !serial_tx_flag
    |=> peripheral_irq) else $error("irq dropped");
  a_no_wait: assert property (psel && penable |-> pready) else $error("wait state");
  cover property (cpu_irq);
  cover property (rd && paddr == 12'h00c);
  cover property (pslverr);
endmodule
bind pif_irq_group pif_chk u_chk(.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
  .serial_rx_flag(serial_rx_flag), .serial_tx_flag(serial_tx_flag),
  .peripheral_irq(peripheral_irq), .cpu_irq(cpu_irq), .paddr(paddr), .prdata(prdata));

/* File: test/test_peripheral_irq_enable_flags.sv */
// Bench for the peripheral interrupt group; APB tasks plus event source model.
`timescale 1ns/1ps
module test_peripheral_irq_enable_flags;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, peripheral_irq, cpu_irq;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rv;
  logic pready, pslverr, rx, tx, se;
  logic [7:0] ev;
  int bad_count = 0, n_checks = 0, cyc = 0;
  pif_src_model src(.pclk(pclk), .src_event(ev), .rx(rx), .tx(tx));
  pif_irq_group DUT(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_event(ev), .serial_rx_flag(rx), .serial_tx_flag(tx),
    .peripheral_irq(peripheral_irq), .cpu_irq(cpu_irq));
  always #10 pclk = ~pclk;
  // One APB transfer, read data taken at the completing edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    se = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(rv, e);
  endtask
  task irq(input logic [1:0] e);
    @(negedge pclk) chk({cpu_irq, peripheral_irq}, e);
  endtask
  task test_done;
    $display("errors %0d checks %0d", bad_count, n_checks);
    if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      test_done;
    end
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    rd(12'h08c, 0);
    chk({31'h0, se}, 0);
    rd(12'h00c, 0);
    apb(1, 12'h08c, 32'hff);
    rd(12'h08c, 32'hff);
    apb(1, 12'h08c, 0);
    src.pulse(8'hff);
    rd(12'h00c, 32'hcf);
    src.ser(2'b11);
    rd(12'h00c, 32'hff);
    apb(1, 12'h00c, 0);
    rd(12'h00c, 32'h30);
    src.ser(2'b00);
    apb(1, 12'h00c, 32'h30);
    rd(12'h00c, 0);
    apb(1, 12'h08c, 1);
    src.pulse(8'h01);
    irq(2'b00);
    apb(1, 12'h010, 32'h40);
    irq(2'b01);
    apb(1, 12'h010, 32'hc0);
    irq(2'b11);
    rd(12'h100, 0);
    chk({31'h0, se}, 1);
    @(posedge pclk) presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    rd(12'h08c, 0);
    irq(2'b00);
    test_done;
  end
endmodule
